// File: core/tcc_pkg.sv
// Constants and types shared by the timer main control block
package tcc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_MASK    = 8'h08;
  localparam logic [7:0] ADR_RELOAD  = 8'h0c;
  localparam logic [7:0] ADR_COUNT   = 8'h10;
  localparam logic [7:0] ADR_EVGEN   = 8'h14;
  localparam logic [7:0] ADR_COMPARE = 8'h18;

  // Reset values and write masks
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_bbff;
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;

  // Event status bits, shared by status and mask registers, and the update bit of the event generation register
  localparam int STS_W   = 3;
  localparam int STS_UPD = 0;
  localparam int STS_CMP = 1;
  localparam int STS_TRG = 2;
  localparam int EVG_UPD = 0;

  // Alignment codes
  localparam logic [1:0] ALIGN_EDGE = 2'h0;
  localparam logic [1:0] ALIGN_DOWN = 2'h1;
  localparam logic [1:0] ALIGN_UP   = 2'h2;
  localparam logic [1:0] ALIGN_BOTH = 2'h3;

  // Filter clock divider codes
  localparam logic [1:0] DIV_1   = 2'h0;
  localparam logic [1:0] DIV_2   = 2'h1;
  localparam logic [1:0] DIV_4   = 2'h2;
  localparam logic [1:0] DIV_BAD = 2'h3;

  // Control register layout
  typedef struct packed {
    logic [15:0] rsvd_hi;
    logic        ref_clear_source_sel;
    logic        rsvd_14;
    logic        third_channel_source;
    logic        second_channel_source;
    logic        first_channel_source;
    logic        rsvd_10;
    logic [1:0]  filter_clock_divider;
    logic        reload_buffer_en;
    logic [1:0]  align_mode_sel;
    logic        count_down;
    logic        single_shot_en;
    logic        update_source_sel;
    logic        update_inhibit;
    logic        counter_run;
  } tcc_ctrl_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcc_wb_req_t;

endpackage

// File: core/tcc_sample_div.sv
// Filter sample period divider driven by the clock division field
`timescale 1ns/100ps
module tcc_sample_div (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Division code
  input  wire logic [1:0] div_code_i,
  // Sample strobe
  output logic            sample_tick_o
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } tcc_div_state_t;

  tcc_div_state_t st;
  tcc_div_state_t next_st;

  // Wrap mask for each code; the forbidden code behaves as divide by four
  function automatic logic [1:0] div_mask(input logic [1:0] code);
    unique case (code)
      DIV_1:   div_mask = 2'h0;
      DIV_2:   div_mask = 2'h1;
      DIV_4:   div_mask = 2'h3;
      DIV_BAD: div_mask = 2'h3;
    endcase
  endfunction

  always_comb begin
    next_st      = st;
    next_st.cnt  = (st.cnt + 2'h1) & div_mask(div_code_i);
    next_st.tick = (st.cnt & div_mask(div_code_i)) == div_mask(div_code_i);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sample_tick_o = st.tick;

  a_sample_div2: assert property (@(posedge clk_i) disable iff (rst_i)
    (div_code_i == DIV_2 && sample_tick_o) ##1 (div_code_i == DIV_2) |-> !sample_tick_o)
    else $error("Divide-by-two strobe came on two cycles in a row");
  a_sample_div1: assert property (@(posedge clk_i) disable iff (rst_i)
    (div_code_i == DIV_1)[*2] |-> sample_tick_o)
    else $error("Undivided strobe missing");
endmodule

// File: core/tcc_timer.sv
// Timer main control: register file, counter core, update events and input routing
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module tcc_timer (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire tcc_pkg::tcc_wb_req_t wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Slave mode controller
  input  wire logic                 slave_update_i,
  input  wire logic                 trigger_mode_i,
  input  wire logic                 trigger_i,
  input  wire logic                 encoder_mode_i,
  input  wire logic                 encoder_dir_i,
  // Signal sources
  input  wire logic                 external_trigger_input_i,
  input  wire logic                 comp_clear_i,
  input  wire logic                 comp_ch1_i,
  input  wire logic [2:0]           pin_ch_i,
  // Routed signals
  output logic                      ref_clear_o,
  output logic [2:0]                channel_o,
  output logic                      sample_tick_o,
  // Counter and events
  output logic [15:0]               counter_o,
  output logic                      counter_run_o,
  output logic                      update_event_o,
  output logic                      update_request_o,
  output logic                      irq_o
);
  import tcc_pkg::*;

  typedef struct packed {
    tcc_ctrl_t         ctrl;
    logic [15:0]       reload_pre;
    logic [15:0]       reload_act;
    logic [15:0]       cmp_pre;
    logic [15:0]       cmp_act;
    logic [15:0]       cnt;
    logic              hw_down;
    logic [STS_W-1:0]  status;
    logic [STS_W-1:0]  mask;
    logic              ack;
    logic [31:0]       rdata;
    logic              irq;
    logic              update_event;
    logic              upd_req;
    logic              ref_clear;
    logic [2:0]        chan;
  } tcc_state_t;

  tcc_state_t  st;
  tcc_state_t  next_st;
  logic        bus_acc;
  logic        bus_wr;
  logic [31:0] wdata_ctrl;
  logic        soft_upd;
  logic        center;
  logic        down_now;
  logic        dir_view;

  // Byte-lane merge of write data into an old register value
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    wb_merge = res;
  endfunction

  // Whether a compare match may flag in the present direction
  function automatic logic cmp_dir_ok(input logic [1:0] align, input logic down);
    unique case (align)
      ALIGN_EDGE: cmp_dir_ok = 1'b1;
      ALIGN_DOWN: cmp_dir_ok = down;
      ALIGN_UP:   cmp_dir_ok = !down;
      ALIGN_BOTH: cmp_dir_ok = 1'b1;
    endcase
  endfunction

  // Bus decode and shared terms
  assign bus_acc    = wb_req_i.cyc && wb_req_i.stb && !st.ack;
  assign bus_wr     = bus_acc && wb_req_i.we;
  assign wdata_ctrl = wb_merge(st.ctrl, wb_req_i.dat, wb_req_i.sel) & CTRL_WMASK;
  assign soft_upd   = bus_wr && wb_req_i.adr == ADR_EVGEN && wb_req_i.sel[0]
                      && wb_req_i.dat[EVG_UPD];
  assign center     = st.ctrl.align_mode_sel != ALIGN_EDGE;
  assign down_now   = center ? st.hw_down : st.ctrl.count_down;
  assign dir_view   = encoder_mode_i ? encoder_dir_i : st.hw_down;

  // Next-state logic
  always_comb begin
    logic ovf;
    logic udf;
    logic any_upd;
    logic update_event;
    logic [31:0] rd;
    tcc_ctrl_t   cv;
    ovf     = 1'b0;
    udf     = 1'b0;
    any_upd = 1'b0;
    update_event     = 1'b0;
    rd      = '0;
    cv      = st.ctrl;
    next_st         = st;
    next_st.ack     = bus_acc;
    next_st.update_event     = 1'b0;
    next_st.upd_req = 1'b0;

    // Register writes
    if (bus_wr) begin
      unique case (wb_req_i.adr)
        ADR_CTRL: begin
          next_st.ctrl = wdata_ctrl;
          if (center || encoder_mode_i) begin
            next_st.ctrl.count_down = st.ctrl.count_down;
          end
        end
        ADR_STATUS: next_st.status = st.status & ~wb_req_i.dat[STS_W-1:0];
        ADR_MASK:   next_st.mask   = wb_req_i.dat[STS_W-1:0];
        ADR_RELOAD: begin
          next_st.reload_pre = 16'(wb_merge({16'h0000, st.reload_pre}, wb_req_i.dat,
                                            wb_req_i.sel));
          if (!st.ctrl.reload_buffer_en) begin
            next_st.reload_act = next_st.reload_pre;
          end
        end
        ADR_COMPARE: begin
          next_st.cmp_pre = 16'(wb_merge({16'h0000, st.cmp_pre}, wb_req_i.dat,
                                         wb_req_i.sel));
        end
        default: ;
      endcase
    end

    if (st.ctrl.counter_run) begin
      if (!down_now) begin
        if (st.cnt >= st.reload_act) begin
          ovf = 1'b1;
          if (center) begin
            next_st.cnt     = (st.cnt == COUNT_ZERO) ? COUNT_ZERO : st.cnt - COUNT_ONE;
            next_st.hw_down = 1'b1;
          end else begin
            next_st.cnt = COUNT_ZERO;
          end
        end else begin
          next_st.cnt = st.cnt + COUNT_ONE;
        end
      end else begin
        if (st.cnt == COUNT_ZERO) begin
          udf = 1'b1;
          if (center) begin
            next_st.cnt     = (st.reload_act == COUNT_ZERO) ? COUNT_ZERO : COUNT_ONE;
            next_st.hw_down = 1'b0;
          end else begin
            next_st.cnt = st.reload_act;
          end
        end else begin
          next_st.cnt = st.cnt - COUNT_ONE;
        end
      end
      if (st.cnt == st.cmp_act && cmp_dir_ok(st.ctrl.align_mode_sel, down_now)) begin
        next_st.status[STS_CMP] = 1'b1;
      end
    end

    any_upd = ovf || udf || soft_upd || slave_update_i;
    update_event = any_upd && !st.ctrl.update_inhibit;
    next_st.update_event = update_event;
    if (update_event) begin
      next_st.reload_act = next_st.reload_pre;
      next_st.cmp_act    = next_st.cmp_pre;
      if (!st.ctrl.update_source_sel || ovf || udf) begin
        next_st.upd_req         = 1'b1;
        next_st.status[STS_UPD] = 1'b1;
      end
      if (st.ctrl.single_shot_en) begin
        next_st.ctrl.counter_run = 1'b0;
      end
    end

    if (soft_upd || slave_update_i) begin
      next_st.cnt     = (!center && st.ctrl.count_down) ? next_st.reload_act : COUNT_ZERO;
      next_st.hw_down = 1'b0;
    end

    if (trigger_mode_i && trigger_i) begin
      next_st.ctrl.counter_run = 1'b1;
      next_st.status[STS_TRG]  = 1'b1;
    end

    // Read data
    unique case (wb_req_i.adr)
      ADR_CTRL: begin
        if (center || encoder_mode_i) begin
          cv.count_down = dir_view;
        end
        rd = cv;
      end
      ADR_STATUS:  rd[STS_W-1:0] = st.status;
      ADR_MASK:    rd[STS_W-1:0] = st.mask;
      ADR_RELOAD:  rd[15:0] = st.reload_pre;
      ADR_COUNT:   rd[15:0] = st.cnt;
      ADR_COMPARE: rd[15:0] = st.cmp_pre;
      default:     rd = '0;
    endcase
    next_st.rdata = (bus_acc && !wb_req_i.we) ? rd : '0;

    next_st.irq = |(next_st.status & next_st.mask);

    next_st.ref_clear = st.ctrl.ref_clear_source_sel ? comp_clear_i
                                                     : external_trigger_input_i;
    next_st.chan[0] = st.ctrl.first_channel_source ? comp_ch1_i : pin_ch_i[0];
    // channels 2 and 3 from pins
    next_st.chan[2:1] = pin_ch_i[2:1];
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= '0;
      st.ctrl       <= CTRL_RESET;
      st.reload_pre <= RELOAD_RESET;
      st.reload_act <= RELOAD_RESET;
      st.cmp_pre    <= COMPARE_RESET;
      st.cmp_act    <= COMPARE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Filter sample period divider
  tcc_sample_div u_sample_div (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .div_code_i    (st.ctrl.filter_clock_divider),
    .sample_tick_o (sample_tick_o)
  );

  // Outputs from state
  assign wb_dat_o         = st.rdata;
  assign wb_ack_o         = st.ack;
  assign ref_clear_o      = st.ref_clear;
  assign channel_o        = st.chan;
  assign counter_o        = st.cnt;
  assign counter_run_o    = st.ctrl.counter_run;
  assign update_event_o   = st.update_event;
  assign update_request_o = st.upd_req;
  assign irq_o            = st.irq;

  a_ref_clear_src: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ref_clear_o == ($past(st.ctrl.ref_clear_source_sel) ? $past(comp_clear_i)
                                                            : $past(external_trigger_input_i)))
    else $error("Reference clear from wrong source");

  a_ch1_route: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl.first_channel_source |=> channel_o[0] == $past(comp_ch1_i))
    else $error("Channel 1 not taken from comparator");

  a_chan_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 channel_o[2:1] == $past(pin_ch_i[2:1]))
    else $error("Channel 2 or 3 not taken from pin");

  a_reload_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_wr && wb_req_i.adr == ADR_RELOAD && wb_req_i.sel == 4'hf
     && !st.ctrl.reload_buffer_en && !slave_update_i && !soft_upd
     && !st.ctrl.counter_run)
    |=> st.reload_act == $past(wb_req_i.dat[15:0]))
    else $error("Unbuffered reload write did not take effect");

  a_edge_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (!center && st.ctrl.counter_run && !st.ctrl.count_down && st.cnt == st.reload_act
     && !slave_update_i && !soft_upd) |=> st.cnt == COUNT_ZERO ##0 update_event_o
     || $past(st.ctrl.update_inhibit))
    else $error("Edge-aligned up count did not wrap to zero");

  a_center_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctrl.align_mode_sel == ALIGN_DOWN && st.ctrl.counter_run && !st.hw_down
     && !st.status[STS_CMP] && !(bus_wr && wb_req_i.adr == ADR_STATUS))
    |=> !st.status[STS_CMP])
    else $error("Compare flag set while counting up in down-only mode");

  a_dir_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (center && bus_wr && wb_req_i.adr == ADR_CTRL) |=> $stable(st.ctrl.count_down))
    else $error("Direction bit written in center-aligned mode");

  a_single_shot: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_event_o && $past(st.ctrl.single_shot_en) && !$past(trigger_i)
     && !$past(bus_wr && wb_req_i.adr == ADR_CTRL)) |-> !counter_run_o)
    else $error("Single shot did not stop the counter");

  a_req_source: assert property (@(posedge clk_i) disable iff (rst_i)
    (update_event_o && !update_request_o) |-> $past(st.ctrl.update_source_sel))
    else $error("Update request suppressed without source select");

  a_inhibit_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl.update_inhibit |=> !update_event_o)
    else $error("Update event raised while inhibited");

  a_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.ctrl.counter_run && !soft_upd && !slave_update_i) |=> $stable(st.cnt))
    else $error("Counter moved while disabled");

  a_trigger_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (trigger_mode_i && trigger_i) |=> counter_run_o)
    else $error("Trigger did not start the counter");

  a_center_turn: assert property (@(posedge clk_i) disable iff (rst_i)
    (center && st.ctrl.counter_run && !st.hw_down && st.cnt == st.reload_act
     && st.cnt != COUNT_ZERO && !soft_upd && !slave_update_i)
    |=> st.hw_down && st.cnt == $past(st.cnt) - COUNT_ONE)
    else $error("Center-aligned counter did not turn at the top");
endmodule

// File: tb/testbench.sv
// Self-checking bench for the timer main control block
`timescale 1ns/100ps
module testbench;
  import tcc_pkg::*;

  // Stimulus and observed signals
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  tcc_wb_req_t req      = '0;
  logic        slv_upd  = 1'b0;
  logic        trg_mode = 1'b0;
  logic        trg      = 1'b0;
  logic        enc_mode = 1'b0;
  logic        enc_dir  = 1'b0;
  logic        ext_trg  = 1'b0;
  logic        cmp_clr  = 1'b0;
  logic        cmp_ch1  = 1'b0;
  logic [2:0]  pin_ch   = 3'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ref_clear_o;
  logic [2:0]  channel_o;
  logic        sample_tick_o;
  logic [15:0] counter_o;
  logic        counter_run_o;
  logic        update_event_o;
  logic        update_request_o;
  logic        irq_o;
  logic [31:0] q;
  logic [15:0] mx;
  int          err_count = 0;
  int          cmp_count = 0;
  int          ev_cnt    = 0;
  int          rq_cnt    = 0;
  int          tk_cnt    = 0;
  int          e0, r0, t0, bad, i, n;
  logic        dn;

  tcc_timer tcc_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .slave_update_i(slv_upd), .trigger_mode_i(trg_mode),
    .trigger_i(trg), .encoder_mode_i(enc_mode), .encoder_dir_i(enc_dir),
    .external_trigger_input_i(ext_trg), .comp_clear_i(cmp_clr),
    .comp_ch1_i(cmp_ch1), .pin_ch_i(pin_ch), .ref_clear_o(ref_clear_o),
    .channel_o(channel_o), .sample_tick_o(sample_tick_o), .counter_o(counter_o),
    .counter_run_o(counter_run_o), .update_event_o(update_event_o),
    .update_request_o(update_request_o), .irq_o(irq_o));

  // Clock
  always #5 clk_i = ~clk_i;

  // Pulse counters for events, requests and sample ticks
  always @(posedge clk_i) begin
    ev_cnt <= ev_cnt + int'(update_event_o === 1'b1);
    rq_cnt <= rq_cnt + int'(update_request_o === 1'b1);
    tk_cnt <= tk_cnt + int'(sample_tick_o === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // One classic Wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    req <= '0;
    chk("bus ack", 32'(k < 50), 32'h1);
  endtask

  task automatic soft_upd();
    wb(1'b1, ADR_EVGEN, 32'h0000_0001);
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    wt(20000);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    wt(2);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl reset", q, CTRL_RESET);
    wb(1'b0, ADR_RELOAD, 32'h0);
    chk("reload reset", q, 32'(RELOAD_RESET));
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    wb(1'b0, 8'h1c, 32'h0);
    chk("unmapped read", q, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h0000_8a8e);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl mask", q, 32'h0000_8a8e);
    cmp_clr <= 1'b1;
    cmp_ch1 <= 1'b1;
    pin_ch  <= 3'h6;
    wt(3);
    chk("ref clear comp", 32'(ref_clear_o), 32'h1);
    chk("channels comp", 32'(channel_o), 32'h7);
    wb(1'b1, ADR_CTRL, 32'h0);
    ext_trg <= 1'b1;
    cmp_clr <= 1'b0;
    wt(3);
    chk("ref clear ext", 32'(ref_clear_o), 32'h1);
    chk("channels pin", 32'(channel_o), 32'h6);
    for (i = 0; i < 3; i++) begin
      wb(1'b1, ADR_CTRL, 32'(i) << 8);
      wt(4);
      t0 = tk_cnt;
      wt(8);
      chk("sample ticks", 32'(tk_cnt - t0), 32'(8 >> i));
    end
    wb(1'b1, ADR_RELOAD, 32'h3);
    wb(1'b1, ADR_MASK, 32'h1);
    e0 = ev_cnt;
    wb(1'b1, ADR_CTRL, 32'h9);
    for (n = 0; n < 40 && counter_run_o === 1'b1; n++) @(posedge clk_i);
    wt(2);
    chk("single shot stop", 32'(counter_run_o), 32'h0);
    chk("single shot events", 32'(ev_cnt - e0), 32'h1);
    chk("wrap to zero", 32'(counter_o), 32'h0);
    chk("irq raised", 32'(irq_o), 32'h1);
    wb(1'b1, ADR_STATUS, 32'h7);
    wt(1);
    chk("irq cleared", 32'(irq_o), 32'h0);
    wb(1'b1, ADR_RELOAD, 32'h7);
    e0 = ev_cnt;
    wb(1'b1, ADR_CTRL, 32'h3);
    wt(20);
    wb(1'b1, ADR_CTRL, 32'h2);
    soft_upd();
    wt(3);
    chk("inhibit events", 32'(ev_cnt - e0), 32'h0);
    chk("inhibit reinit", 32'(counter_o), 32'h0);
    wb(1'b1, ADR_MASK, 32'h0);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, ADR_CTRL, i[0] ? 32'h4 : 32'h0);
      e0 = ev_cnt;
      r0 = rq_cnt;
      if (i[1]) begin
        slv_upd <= 1'b1;
        wt(1);
        slv_upd <= 1'b0;
      end else begin
        soft_upd();
      end
      wt(4);
      chk("update events", 32'(ev_cnt - e0), 32'h1);
      chk("update requests", 32'(rq_cnt - r0), 32'(!i[0]));
    end
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status set", q & 32'h1, 32'h1);
    chk("irq masked", 32'(irq_o), 32'h0);
    wb(1'b1, ADR_STATUS, 32'h7);
    wb(1'b1, ADR_CTRL, 32'h80);
    wb(1'b1, ADR_RELOAD, 32'h2);
    wb(1'b0, ADR_RELOAD, 32'h0);
    chk("reload preload", q & 32'hffff, 32'h2);
    wb(1'b1, ADR_CTRL, 32'h81);
    wt(6);
    chk("old reload active", 32'(counter_o > 16'h2), 32'h1);
    soft_upd();
    wt(2);
    bad = 0;
    repeat (12) begin
      @(posedge clk_i);
      bad += int'(counter_o > 16'h2);
    end
    chk("new reload active", 32'(bad), 32'h0);
    wb(1'b1, ADR_CTRL, 32'h0);
    e0 = ev_cnt;
    wb(1'b1, ADR_CTRL, 32'h11);
    bad = 0;
    repeat (12) begin
      @(posedge clk_i);
      bad += int'(counter_o > 16'h2);
    end
    chk("down range", 32'(bad), 32'h0);
    chk("down underflows", 32'(ev_cnt - e0 >= 3), 32'h1);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("dir bit", 32'(q[4]), 32'h1);
    wb(1'b1, ADR_CTRL, 32'h0);
    // Center mode is entered only while stopped
    wb(1'b1, ADR_CTRL, 32'h20);
    wb(1'b1, ADR_CTRL, 32'h21);
    mx = 16'h0;
    dn = 1'b0;
    repeat (16) begin
      @(posedge clk_i);
      if (counter_o > mx) mx = counter_o;
      if (counter_o < mx) dn = 1'b1;
    end
    chk("center top", 32'(mx), 32'h2);
    chk("center descends", 32'(dn), 32'h1);
    wb(1'b1, ADR_CTRL, 32'h0);
    // Compare at the top is only met counting up: flag per alignment code
    for (i = 1; i < 4; i++) begin
      wb(1'b1, ADR_CTRL, 32'(i) << 5);
      wb(1'b1, ADR_COMPARE, 32'h2);
      soft_upd();
      wb(1'b1, ADR_STATUS, 32'h7);
      wb(1'b1, ADR_CTRL, (32'(i) << 5) | 32'h1);
      wt(12);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("compare flag", (q >> 1) & 32'h1, 32'(i != 1));
    end
    enc_mode <= 1'b1;
    enc_dir  <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("encoder dir up", 32'(q[4]), 32'h1);
    enc_dir <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h10);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("encoder dir ro", 32'(q[4]), 32'h0);
    enc_mode <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h0);
    trg_mode <= 1'b1;
    trg      <= 1'b1;
    wt(1);
    trg <= 1'b0;
    wt(2);
    chk("trigger start", 32'(counter_run_o), 32'h1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("trigger flag", q & 32'h4, 32'h4);
    trg_mode <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h0);
    wt(2);
    chk("software stop", 32'(counter_run_o), 32'h0);
    results();
  end
endmodule
